// ==== hw/bcr_params.svh ====
// offsets, field positions, reset values for the bus control register bank
// assumes inclusion by the bank module and the testbench
`ifndef BCR_PARAMS_SVH
`define BCR_PARAMS_SVH
`define BCR_ADDR_W 8
`define BCR_OFF_IDLE_BURST 8'h00
`define BCR_OFF_REL_WAIT 8'h01
`define BCR_OFF_ADDR_OUT 8'h02
`define BCR_RST_IDLE_BURST 8'hD0
`define BCR_RST_REL_WAIT 8'h08
`define BCR_RST_AE_ROMLESS 4'hD
`define BCR_RST_AE_ROM 4'h0
`define BCR_BIT_IDLE_AREAS 7
`define BCR_BIT_IDLE_RW 6
`define BCR_BIT_AREA0_BURST 5
`define BCR_BIT_BURST_LEN 4
`define BCR_BIT_BURST_WORDS 3
`define BCR_BIT_REL_EN 7
`define BCR_BIT_FIXED_ZERO 5
`define BCR_BIT_WAIT_EN 0
`define BCR_MODE_ROMLESS_A 3'h4
`define BCR_MODE_ROMLESS_B 3'h5
`define BCR_MODE_ROM_A 3'h6
`define BCR_MODE_ROM_B 3'h7
`define BCR_BURST_STATES_SHORT 2'h1
`define BCR_BURST_STATES_LONG 2'h2
`define BCR_BURST_WORDS_FEW 4'h4
`define BCR_BURST_WORDS_MANY 4'h8
`endif

// ==== hw/bcr_pkg.sv ====
// types shared by the bus control register bank
// assumes bcr_params.svh on the include path
package bcr_pkg;
	typedef struct packed {
		logic start;
		logic [2:0] area;
		logic write;
		logic external;
	} bcr_cyc_s;
	typedef struct packed {
		logic [7:0] idle_burst_control;
		logic [7:0] bus_release_wait_control;
		logic [7:0] address_output_control;
	} bcr_regs_s;
endpackage

// ==== hw/bcr_regs.sv ====
// bus controller control register bank: idle insertion, area 0 burst settings,
// bus release and wait enables, upper address pin enables
// assumes a single 50 MHz clock and a one-cycle strobe register port
//
// Contract
// - idle/burst register becomes D0 hex on power-on or hardware standby only.
// - idle bit set inserts one idle between reads in different areas.
// - read-write idle bit set inserts one idle between read and next write.
// - area 0 uses basic interface when burst select is 0, burst ROM when 1.
// - burst cycle lasts one state when length bit 0, two states when 1.
// - burst access limited to four words when limit bit 0, eight when 1.
// - release/wait register becomes 08 hex on power-on or hardware standby only.
// - bus released only with release enable; otherwise request pins are ports.
// - wait input sampled only with wait enable; otherwise wait pin is port.
// - bit 5 of release/wait register is not writable and reads 0.
// - address output register resets 0D hex in modes 4,5 and 00 in 6,7.
// - field k enables A8 upward through A(7+k); 15 enables A8 to A23.
// - selected pins drive address regardless of direction; others port when direction 1.
// - romless expanded mode resets field to 1101 and always drives A0 to A7.
// - expanded mode with ROM resets field to 0000; A0-A7 follow direction bits.
`timescale 1ns/1ps
`include "bcr_params.svh"

module bcr_regs
	import bcr_pkg::*;
#(
	parameter int ADDR_PINS = 24
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic hw_standby_in,
	input wire logic [2:0] mode_in,
	// register port
	input wire logic [`BCR_ADDR_W-1:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	// bus cycle sequencer
	input wire bcr_cyc_s cyc_in,
	output logic idle_insert_out,
	output logic burst_rom_out,
	output logic [1:0] burst_states_out,
	output logic [3:0] burst_max_words_out,
	// bus release and wait
	input wire logic bus_request_pin_in,
	input wire logic wait_pin_b_in,
	output logic bus_release_out,
	output logic release_pins_port_out,
	output logic wait_stretch_out,
	output logic wait_pin_port_out,
	// address pins
	input wire logic [ADDR_PINS-1:0] addr_in,
	input wire logic [ADDR_PINS-1:0] ddr_in,
	input wire logic [ADDR_PINS-1:0] port_data_in,
	output logic [ADDR_PINS-1:0] addr_pin_out,
	output logic [ADDR_PINS-1:0] addr_pin_oe_out,
	output bcr_regs_s regs_out
);

	// pin loops below are written for the full 24-pin address bus
	if (ADDR_PINS != 24) begin : g_pin_count_check
		$error("bcr_regs serves exactly 24 address pins");
	end

	// field value to upper pin mask
	function automatic logic [15:0] bcr_ae_mask(input logic [3:0] f);
		logic [15:0] m;
		m = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			m[i] = (5'(i) < {1'b0, f}) || (f == 4'hF);
		end
		return m;
	endfunction

	function automatic logic bcr_is_romless(input logic [2:0] m);
		return (m == `BCR_MODE_ROMLESS_A) || (m == `BCR_MODE_ROMLESS_B);
	endfunction

	function automatic logic bcr_is_expanded(input logic [2:0] m);
		return bcr_is_romless(m) || (m == `BCR_MODE_ROM_A) || (m == `BCR_MODE_ROM_B);
	endfunction

	logic [7:0] idle_burst_control;
	logic [7:0] bus_release_wait_control;
	logic [3:0] address_output_enable_field;
	logic init_pend;
	logic romless;
	logic expanded;
	logic load_init;
	logic prev_valid;
	logic [2:0] prev_area;
	logic prev_write;
	logic next_idle;
	logic [15:0] upper_mask;

	logic idle_between_areas;
	logic idle_read_to_write;
	logic area0_burst_select;
	logic burst_cycle_length;
	logic burst_word_limit;
	logic bus_release_enable;
	logic wait_pin_enable;

	assign idle_between_areas = idle_burst_control[`BCR_BIT_IDLE_AREAS];
	assign idle_read_to_write = idle_burst_control[`BCR_BIT_IDLE_RW];
	assign area0_burst_select = idle_burst_control[`BCR_BIT_AREA0_BURST];
	assign burst_cycle_length = idle_burst_control[`BCR_BIT_BURST_LEN];
	assign burst_word_limit = idle_burst_control[`BCR_BIT_BURST_WORDS];
	assign bus_release_enable = bus_release_wait_control[`BCR_BIT_REL_EN];
	assign wait_pin_enable = bus_release_wait_control[`BCR_BIT_WAIT_EN];

	// init pulse: first edge after power-on release, or any standby cycle
	assign load_init = init_pend || hw_standby_in;

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			init_pend <= 1'b1;
		end else begin
			init_pend <= 1'b0;
		end
	end

	// mode captured with the init, not while running
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			romless <= 1'b0;
			expanded <= 1'b0;
		end else if (load_init) begin
			romless <= bcr_is_romless(mode_in);
			expanded <= bcr_is_expanded(mode_in);
		end
	end

	// no manual-reset input: only power-on and standby reinitialise
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			idle_burst_control <= `BCR_RST_IDLE_BURST;
		end else if (hw_standby_in) begin
			idle_burst_control <= `BCR_RST_IDLE_BURST;
		end else if (reg_wr_in && reg_addr_in == `BCR_OFF_IDLE_BURST) begin
			idle_burst_control <= reg_wdata_in;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			bus_release_wait_control <= `BCR_RST_REL_WAIT;
		end else if (hw_standby_in) begin
			bus_release_wait_control <= `BCR_RST_REL_WAIT;
		end else if (reg_wr_in && reg_addr_in == `BCR_OFF_REL_WAIT) begin
			// bit 5 forced to 0, other bits kept as written; software keeps bit 3 high
			bus_release_wait_control <= reg_wdata_in & ~(8'h01 << `BCR_BIT_FIXED_ZERO);
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			address_output_enable_field <= `BCR_RST_AE_ROM;
		end else if (load_init) begin
			address_output_enable_field <= bcr_is_romless(mode_in) ?
				`BCR_RST_AE_ROMLESS : `BCR_RST_AE_ROM;
		end else if (reg_wr_in && reg_addr_in == `BCR_OFF_ADDR_OUT) begin
			address_output_enable_field <= reg_wdata_in[3:0];
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				`BCR_OFF_IDLE_BURST: reg_rdata_out <= idle_burst_control;
				`BCR_OFF_REL_WAIT: reg_rdata_out <= bus_release_wait_control;
				`BCR_OFF_ADDR_OUT: reg_rdata_out <= {4'h0, address_output_enable_field};
				default: reg_rdata_out <= 8'h00;
			endcase
		end else begin
			reg_rdata_out <= 8'h00;
		end
	end

	assign regs_out = '{idle_burst_control, bus_release_wait_control,
		{4'h0, address_output_enable_field}};

	// last external cycle, for idle decisions
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			prev_valid <= 1'b0;
			prev_area <= 3'h0;
			prev_write <= 1'b0;
		end else if (cyc_in.start && cyc_in.external) begin
			prev_valid <= 1'b1;
			prev_area <= cyc_in.area;
			prev_write <= cyc_in.write;
		end
	end

	// one flag, so both conditions still give a single idle state
	always_comb begin
		next_idle = 1'b0;
		if (cyc_in.start && cyc_in.external && prev_valid && !prev_write) begin
			if (idle_between_areas && !cyc_in.write && cyc_in.area != prev_area) begin
				next_idle = 1'b1;
			end
			if (idle_read_to_write && cyc_in.write) begin
				next_idle = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			idle_insert_out <= 1'b0;
		end else begin
			idle_insert_out <= next_idle;
		end
	end

	// burst settings for the area 0 sequencer
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			burst_rom_out <= 1'b0;
			burst_states_out <= `BCR_BURST_STATES_LONG;
			burst_max_words_out <= `BCR_BURST_WORDS_FEW;
		end else begin
			burst_rom_out <= area0_burst_select;
			burst_states_out <= burst_cycle_length ?
				`BCR_BURST_STATES_LONG : `BCR_BURST_STATES_SHORT;
			burst_max_words_out <= burst_word_limit ?
				`BCR_BURST_WORDS_MANY : `BCR_BURST_WORDS_FEW;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			bus_release_out <= 1'b0;
			release_pins_port_out <= 1'b1;
			wait_stretch_out <= 1'b0;
			wait_pin_port_out <= 1'b1;
		end else begin
			bus_release_out <= bus_release_enable && bus_request_pin_in;
			release_pins_port_out <= !bus_release_enable;
			wait_stretch_out <= wait_pin_enable && !wait_pin_b_in;
			wait_pin_port_out <= !wait_pin_enable;
		end
	end

	assign upper_mask = bcr_ae_mask(address_output_enable_field);

	// pins: address where enabled, else port data when direction is out
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			addr_pin_out <= '0;
			addr_pin_oe_out <= '0;
		end else begin
			for (int i = 0; i < 8; i++) begin
				if (expanded && (romless || ddr_in[i])) begin
					addr_pin_out[i] <= addr_in[i];
					addr_pin_oe_out[i] <= 1'b1;
				end else begin
					addr_pin_out[i] <= port_data_in[i];
					addr_pin_oe_out[i] <= ddr_in[i];
				end
			end
			for (int i = 8; i < 24; i++) begin
				if (expanded && upper_mask[i-8]) begin
					addr_pin_out[i] <= addr_in[i];
					addr_pin_oe_out[i] <= 1'b1;
				end else begin
					addr_pin_out[i] <= port_data_in[i];
					addr_pin_oe_out[i] <= ddr_in[i];
				end
			end
		end
	end

	// checks
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);

	a_idle_reset_value: assert property ($past(hw_standby_in) |-> idle_burst_control == 8'hD0)
		else $error("idle/burst register not at D0 after standby");
	a_rel_reset_value: assert property ($past(hw_standby_in) |-> bus_release_wait_control == 8'h08)
		else $error("release/wait register not at 08 after standby");
	a_idle_areas: assert property (cyc_in.start && cyc_in.external && prev_valid && !prev_write
		&& !cyc_in.write && cyc_in.area != prev_area && idle_between_areas
		|=> idle_insert_out)
		else $error("missing idle between reads of different areas");
	a_idle_rw: assert property (cyc_in.start && cyc_in.external && prev_valid && !prev_write
		&& cyc_in.write |=> idle_insert_out == $past(idle_read_to_write))
		else $error("read to write idle wrong");
	a_idle_none: assert property (!idle_between_areas && !idle_read_to_write |=> !idle_insert_out)
		else $error("idle inserted with both idle bits clear");
	a_no_idle_after_write: assert property (cyc_in.start && prev_write |=> !idle_insert_out)
		else $error("idle inserted after a write");
	a_burst_len: assert property (##1 burst_states_out == ($past(burst_cycle_length) ? 2'h2 : 2'h1))
		else $error("burst length does not follow its bit");
	a_burst_words: assert property (##1 burst_max_words_out == ($past(burst_word_limit) ? 4'h8 : 4'h4))
		else $error("burst word limit does not follow its bit");
	a_burst_sel: assert property (##1 burst_rom_out == $past(area0_burst_select))
		else $error("area 0 interface choice wrong");
	a_release_gate: assert property (bus_release_out |-> $past(bus_release_enable) && $past(bus_request_pin_in))
		else $error("bus released while disabled");
	a_release_off: assert property (!bus_release_enable |=> !bus_release_out)
		else $error("bus released with release disabled");
	a_port_flags: assert property (bus_release_enable |=> !release_pins_port_out)
		else $error("request pins left as ports with release enabled");
	a_wait_off: assert property (!wait_pin_enable |=> wait_pin_port_out && !wait_stretch_out)
		else $error("wait pin not a port while wait disabled");
	a_wait_gate: assert property (!wait_pin_enable ##1 !wait_pin_enable |-> !wait_stretch_out)
		else $error("wait sampled while disabled");
	a_fixed_zero: assert property (reg_rd_in && reg_addr_in == `BCR_OFF_REL_WAIT |=> !reg_rdata_out[5])
		else $error("fixed zero bit read as one");
	a_ae_init: assert property ($past(hw_standby_in) |->
		address_output_enable_field == (bcr_is_romless($past(mode_in)) ? 4'hD : 4'h0))
		else $error("address field init does not match mode");
	a_power_on_ae: assert property (init_pend |=>
		address_output_enable_field == (romless ? `BCR_RST_AE_ROMLESS : `BCR_RST_AE_ROM))
		else $error("address field not loaded from mode after power-on");
	a_rel_zero_kept: assert property (!bus_release_wait_control[`BCR_BIT_FIXED_ZERO])
		else $error("fixed zero bit stored as one");
	a_upper_pin: assert property (expanded && upper_mask[0] |=> addr_pin_oe_out[8])
		else $error("enabled A8 not driven");
	a_low_romless: assert property (expanded && romless |=> addr_pin_oe_out[7:0] == 8'hFF)
		else $error("romless low address pins not driven");
	a_low_rom_port: assert property (expanded && !romless && !ddr_in[4] |=> !addr_pin_oe_out[4])
		else $error("low address pin driven with direction bit clear");
	a_low_rom_addr: assert property (expanded && !romless && ddr_in[0] |=> addr_pin_oe_out[0])
		else $error("low address pin not driven with direction bit set");
	a_upper_port: assert property (!upper_mask[14] && !ddr_in[22] |=> !addr_pin_oe_out[22])
		else $error("unselected upper pin driven with direction bit clear");

	c_idle_inserted: cover property (idle_insert_out);
	c_burst_rom: cover property (burst_rom_out && burst_max_words_out == 4'h8);
	c_release: cover property (bus_release_out);
	c_wait_stretch: cover property (wait_stretch_out);
	c_full_upper: cover property (address_output_enable_field == 4'hF && expanded);

endmodule // bcr_regs

// ==== sim/bcr_far_side.sv ====
// far-side model: bus requester and wait source on the external bus
// assumes the bench tells it when to want the bus and when to stretch
`timescale 1ns/1ps
module bcr_far_side (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	// bench commands
	input wire logic want_bus_in,
	input wire logic want_wait_in,
	// pins toward the bank
	output logic bus_request_pin_out,
	output logic wait_pin_b_out
);
	// request held while the bus is wanted
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			bus_request_pin_out <= 1'b0;
		end else begin
			bus_request_pin_out <= want_bus_in;
		end
	end
	// wait line rests at its pulled-up level unless stretching
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wait_pin_b_out <= 1'b1;
		end else begin
			wait_pin_b_out <= ~want_wait_in;
		end
	end
endmodule // bcr_far_side

// ==== sim/testbench.sv ====
// self-checking bench for the bus control register bank
// assumes bcr_regs and bcr_far_side are compiled before it
`timescale 1ns/1ps
`include "bcr_params.svh"
module testbench
	import bcr_pkg::*;
;
	logic ref_clk_in, rst_b_in, hw_standby_in, reg_wr_in, reg_rd_in, want_bus, want_wait;
	logic [2:0] mode_in;
	logic [`BCR_ADDR_W-1:0] reg_addr_in;
	logic [7:0] reg_wdata_in, reg_rdata_out;
	bcr_cyc_s cyc_in;
	logic idle_insert_out, burst_rom_out, bus_release_out, release_pins_port_out;
	logic wait_stretch_out, wait_pin_port_out, bus_request_pin_in, wait_pin_b_in;
	logic [1:0] burst_states_out;
	logic [3:0] burst_max_words_out;
	logic [23:0] addr_in, ddr_in, port_data_in, addr_pin_out, addr_pin_oe_out;
	bcr_regs_s regs_out;
	int failures, tests_run;

	bcr_regs #(.ADDR_PINS(24)) dut (.ref_clk_in, .rst_b_in, .hw_standby_in, .mode_in, .reg_addr_in,
		.reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .cyc_in, .idle_insert_out, .burst_rom_out,
		.burst_states_out, .burst_max_words_out, .bus_request_pin_in, .wait_pin_b_in, .bus_release_out,
		.release_pins_port_out, .wait_stretch_out, .wait_pin_port_out, .addr_in, .ddr_in, .port_data_in,
		.addr_pin_out, .addr_pin_oe_out, .regs_out);
	bcr_far_side far (.ref_clk_in, .rst_b_in, .want_bus_in(want_bus), .want_wait_in(want_wait),
		.bus_request_pin_out(bus_request_pin_in), .wait_pin_b_out(wait_pin_b_in));

	initial begin
		ref_clk_in = 1'b0;
		forever #10 ref_clk_in = ~ref_clk_in;
	end

	task chk(input logic [23:0] got, input logic [23:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task settle;
		repeat (3) @(posedge ref_clk_in);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_rd_in <= 1'b0;
		#1 chk(reg_rdata_out, exp);
	endtask
	task do_reset(input logic [2:0] m);
		@(posedge ref_clk_in);
		mode_in <= m;
		rst_b_in <= 1'b0;
		repeat (8) @(posedge ref_clk_in);
		rst_b_in <= 1'b1;
		settle;
	endtask
	// pins selected by the field, plus low pins as the mode dictates
	function logic [23:0] ae_sel(input int k, input logic romless);
		logic [23:0] e;
		e = '0;
		for (int i = 0; i < ((k == 15) ? 16 : k); i++) e[8+i] = 1'b1;
		e[7:0] = romless ? 8'hFF : ddr_in[7:0];
		return e;
	endfunction
	task pin_chk(input int k, input logic romless);
		logic [23:0] e, m;
		e = ae_sel(k, romless);
		m = e | ddr_in;
		chk(addr_pin_oe_out, m);
		chk(addr_pin_out & m, (addr_in & e) | (port_data_in & m & ~e));
	endtask

	task t_reset_values;
		rd_chk(`BCR_OFF_IDLE_BURST, `BCR_RST_IDLE_BURST);
		rd_chk(`BCR_OFF_REL_WAIT, `BCR_RST_REL_WAIT);
		rd_chk(`BCR_OFF_ADDR_OUT, {4'h0, `BCR_RST_AE_ROMLESS});
		chk(burst_rom_out, 1'b0);
		chk(burst_states_out, `BCR_BURST_STATES_LONG);
		chk(burst_max_words_out, `BCR_BURST_WORDS_FEW);
		chk(release_pins_port_out, 1'b1);
		chk(wait_pin_port_out, 1'b1);
		wr(`BCR_OFF_IDLE_BURST, 8'h38);
		wr(`BCR_OFF_REL_WAIT, 8'h89);
		wr(`BCR_OFF_ADDR_OUT, 8'h0F);
		@(posedge ref_clk_in);
		hw_standby_in <= 1'b1;
		@(posedge ref_clk_in);
		hw_standby_in <= 1'b0;
		settle;
		rd_chk(`BCR_OFF_IDLE_BURST, `BCR_RST_IDLE_BURST);
		rd_chk(`BCR_OFF_REL_WAIT, `BCR_RST_REL_WAIT);
		rd_chk(`BCR_OFF_ADDR_OUT, {4'h0, `BCR_RST_AE_ROMLESS});
		$display("reset values test done");
	endtask
	task t_burst;
		wr(`BCR_OFF_IDLE_BURST, 8'h38);
		settle;
		chk(burst_rom_out, 1'b1);
		chk(burst_states_out, `BCR_BURST_STATES_LONG);
		chk(burst_max_words_out, `BCR_BURST_WORDS_MANY);
		wr(`BCR_OFF_IDLE_BURST, 8'h20);
		settle;
		chk(burst_states_out, `BCR_BURST_STATES_SHORT);
		chk(burst_max_words_out, `BCR_BURST_WORDS_FEW);
		wr(`BCR_OFF_IDLE_BURST, 8'h00);
		settle;
		chk(burst_rom_out, 1'b0);
		rd_chk(8'h05, 8'h00);
		$display("burst field test done");
	endtask
	task t_release_wait;
		want_bus <= 1'b1;
		want_wait <= 1'b1;
		settle;
		chk(bus_release_out, 1'b0);
		chk(release_pins_port_out, 1'b1);
		chk(wait_stretch_out, 1'b0);
		chk(wait_pin_port_out, 1'b1);
		wr(`BCR_OFF_REL_WAIT, 8'hA9);
		settle;
		rd_chk(`BCR_OFF_REL_WAIT, 8'h89);
		chk(regs_out.bus_release_wait_control, 8'h89);
		chk(bus_release_out, 1'b1);
		chk(release_pins_port_out, 1'b0);
		chk(wait_stretch_out, 1'b1);
		chk(wait_pin_port_out, 1'b0);
		want_bus <= 1'b0;
		want_wait <= 1'b0;
		settle;
		chk(bus_release_out, 1'b0);
		chk(wait_stretch_out, 1'b0);
		wr(`BCR_OFF_REL_WAIT, 8'h08);
		$display("release and wait test done");
	endtask
	// external read in area 1, then the cycle under test back to back
	task idle_case(input logic [7:0] v, input logic w2, input logic [2:0] a2, input logic exp);
		wr(`BCR_OFF_IDLE_BURST, v);
		@(posedge ref_clk_in);
		cyc_in <= '{1'b1, 3'h1, 1'b0, 1'b1};
		@(posedge ref_clk_in);
		cyc_in <= '{1'b1, a2, w2, 1'b1};
		@(posedge ref_clk_in);
		cyc_in <= '0;
		#1 chk(idle_insert_out, exp);
		@(posedge ref_clk_in);
		#1 chk(idle_insert_out, 1'b0);
	endtask
	task t_idle;
		idle_case(8'h80, 1'b0, 3'h2, 1'b1);
		idle_case(8'h00, 1'b0, 3'h2, 1'b0);
		idle_case(8'h80, 1'b0, 3'h1, 1'b0);
		idle_case(8'h40, 1'b1, 3'h1, 1'b1);
		idle_case(8'h00, 1'b1, 3'h1, 1'b0);
		idle_case(8'hC0, 1'b1, 3'h2, 1'b1);
		$display("idle insertion test done");
	endtask
	task t_addr_pins;
		pin_chk(13, 1'b1);
		for (int k = 0; k < 16; k++) begin
			wr(`BCR_OFF_ADDR_OUT, 8'(k));
			settle;
			pin_chk(k, 1'b1);
		end
		$display("address pin test done");
	endtask
	task t_rom_mode;
		do_reset(3'h6);
		rd_chk(`BCR_OFF_ADDR_OUT, {4'h0, `BCR_RST_AE_ROM});
		pin_chk(0, 1'b0);
		wr(`BCR_OFF_ADDR_OUT, 8'h04);
		settle;
		pin_chk(4, 1'b0);
		do_reset(3'h7);
		rd_chk(`BCR_OFF_ADDR_OUT, {4'h0, `BCR_RST_AE_ROM});
		do_reset(3'h5);
		rd_chk(`BCR_OFF_ADDR_OUT, {4'h0, `BCR_RST_AE_ROMLESS});
		pin_chk(13, 1'b1);
		// single-chip mode: no address pins, everything follows the port
		do_reset(3'h2);
		wr(`BCR_OFF_ADDR_OUT, 8'h0F);
		settle;
		chk(addr_pin_oe_out, ddr_in);
		chk(addr_pin_out & ddr_in, port_data_in & ddr_in);
		$display("rom mode test done");
	endtask

	task report_and_stop;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		failures = 0;
		tests_run = 0;
		rst_b_in = 1'b0;
		hw_standby_in = 1'b0;
		mode_in = 3'h4;
		reg_addr_in = '0;
		reg_wdata_in = 8'h00;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		cyc_in = '0;
		want_bus = 1'b0;
		want_wait = 1'b0;
		addr_in = 24'hC3A55A;
		port_data_in = 24'h3C5AA5;
		ddr_in = 24'h800A0F;
		do_reset(3'h4);
		t_reset_values;
		t_burst;
		t_release_wait;
		t_idle;
		t_addr_pins;
		t_rom_mode;
		report_and_stop;
	end
	// watchdog well beyond the few hundred cycles the tests need
	initial begin
		repeat (5000) @(posedge ref_clk_in);
		failures++;
		report_and_stop;
	end
endmodule // testbench
